/* rtl/pcl_defines.svh */
// Constants of the power-up configuration loader.
// Assumes a 100 MHz loader clock; included by the loader, not by its buffer.
`ifndef PCL_DEFINES_SVH
`define PCL_DEFINES_SVH
`define PCL_CLK_MHZ        100
`define PCL_WAKE_WAIT_NS   30000
`define PCL_WAKE_WAIT_CYC  ((`PCL_WAKE_WAIT_NS * `PCL_CLK_MHZ + 999) / 1000)
`define PCL_OSC_DIV        4
`define PCL_OP_WAKE        8'hab
`define PCL_OP_FREAD       8'h0b
`define PCL_CNT_WAKE       6'h08
`define PCL_CNT_RD3        6'h28
`define PCL_CNT_RD4        6'h30
`define PCL_MODE_ACTIVE    2'h0
`define PCL_MODE_PASSIVE   2'h1
`define PCL_MODE_JTAG      2'h2
`define PCL_MAX_WCODE      3'h3
`define PCL_SEL_EXT        1'b1
`endif

/* rtl/pcl_pkg.sv */
// Types shared by the configuration loader files.
// Assumes nothing beyond a SystemVerilog compiler.
package pcl_pkg;
  typedef logic [7:0] pcl_byte_t;
  typedef enum logic [2:0] {
    ST_IDLE, ST_WAKE, ST_GAP, ST_CMD, ST_READ, ST_PASSIVE, ST_JTAG
  } pcl_state_t;
endpackage : pcl_pkg

/* rtl/pcl_buf.sv */
// Two-entry buffer with valid/ready on both sides.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/10ps
module pcl_buf #(
  parameter int W = 8
) (
  input  wire logic         clk,
  input  wire logic         reset_n,
  input  wire logic [W-1:0] in_data,
  input  wire logic         in_valid,
  output logic              in_ready,
  output logic [W-1:0]      out_data,
  output logic              out_valid,
  input  wire logic         out_ready
);
  generate
    if (W < 1) begin : g_chk
      $error("pcl_buf: W must be at least 1");
    end
  endgenerate

  logic [W-1:0] mem_r [2];
  logic         wp_r;
  logic         rp_r;
  logic [1:0]   cnt_r;

  // Handshake decode; full and empty straight from the count
  wire push = in_valid && in_ready;
  wire pop  = out_valid && out_ready;
  assign in_ready  = (cnt_r != 2'h2);
  assign out_valid = (cnt_r != 2'h0);
  assign out_data  = mem_r[rp_r];

  // Pointers and occupancy
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      wp_r  <= 1'b0;
      rp_r  <= 1'b0;
      cnt_r <= 2'h0;
    end else begin
      if (push) wp_r <= ~wp_r;
      if (pop) rp_r <= ~rp_r;
      cnt_r <= cnt_r + {1'b0, push} - {1'b0, pop};
    end
  end

  // Storage needs no reset; valid comes from the count
  always_ff @(posedge clk) begin
    if (push) mem_r[wp_r] <= in_data;
  end
endmodule : pcl_buf

/* rtl/pcl_loader.sv */
// Power-up configuration loader: active flash read, passive and test-port load.
// Assumes all pins but reset_n and cm_ready asynchronous to ref_clk; bytes leave toward configuration memory.
`timescale 1ns/10ps
`include "pcl_defines.svh"
module pcl_loader #(
  parameter int OSC_DIV = `PCL_OSC_DIV
) (
  input  wire logic        ref_clk,
  input  wire logic        reset_n,
  input  wire logic        config_reset_n,
  input  wire logic [1:0]  mode_sel,
  input  wire logic [2:0]  width_sel,
  input  wire logic        addr4_sel,
  input  wire logic        clk_sel,
  input  wire logic        security_en,
  input  wire logic        external_config_clock,
  output logic             flash_sclk,
  output logic             flash_cs_n,
  output logic             flash_mosi,
  input  wire logic [7:0]  flash_dq_i,
  input  wire logic        pas_clk,
  input  wire logic        pas_cs_n,
  input  wire logic [7:0]  pas_data,
  input  wire logic        jtag_clk,
  input  wire logic        jtag_en,
  input  wire logic        jtag_tdi,
  output pcl_pkg::pcl_byte_t cm_data,
  output logic             cm_valid,
  input  wire logic        cm_ready,
  output logic             busy,
  output logic             width_error,
  output logic             overrun
);
  import pcl_pkg::*;

  generate
    if (OSC_DIV < 2 || OSC_DIV > 256) begin : g_chk
      $error("pcl_loader: OSC_DIV must be 2..256");
    end
  endgenerate

  localparam int WAKE_CYC = `PCL_WAKE_WAIT_CYC;

  // Two-stage synchroniser for every pin but reset_n and cm_ready
  logic [31:0] s1_r;
  logic [31:0] s2_r;
  wire  [31:0] raw = {config_reset_n, mode_sel, width_sel, addr4_sel, clk_sel,
                      security_en, external_config_clock, flash_dq_i, pas_clk,
                      pas_cs_n, pas_data, jtag_clk, jtag_en, jtag_tdi,
                      1'b0}; // Bit 0 spare, keeps the named views aligned
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      s1_r <= 32'h0000_0000;
      s2_r <= 32'h0000_0000;
    end else begin
      s1_r <= raw;
      s2_r <= s1_r;
    end
  end

  // Named views of the synchronised pins
  wire       s_crst  = s2_r[31];
  wire [1:0] s_mode  = s2_r[30:29];
  wire [2:0] s_width = s2_r[28:26];
  wire       s_addr4 = s2_r[25];
  wire       s_csel  = s2_r[24];
  wire       s_sec   = s2_r[23];
  wire       s_ext   = s2_r[22];
  wire [7:0] s_dq    = s2_r[21:14];
  wire       s_pclk  = s2_r[13];
  wire       s_pcs   = s2_r[12];
  wire [7:0] s_pdat  = s2_r[11:4];
  wire       s_jclk  = s2_r[3];
  wire       s_jen   = s2_r[2];
  wire       s_jtdi  = s2_r[1];

  // Edge detectors look at the second stage only
  logic [3:0] prev_r;
  always_ff @(posedge ref_clk) begin
    if (!reset_n) prev_r <= 4'h0;
    else prev_r <= {s_crst, s_ext, s_pclk, s_jclk};
  end
  wire crst_rise = s_crst && !prev_r[3];
  wire ext_rise  = s_ext && !prev_r[2];
  wire pclk_rise = s_pclk && !prev_r[1];
  wire jclk_rise = s_jclk && !prev_r[0];

  // Internal oscillator stand-in: a free divider of ref_clk
  logic [7:0] div_r;
  wire        osc_tick = (div_r == 8'(OSC_DIV - 1));
  always_ff @(posedge ref_clk) begin
    if (!reset_n || osc_tick) div_r <= 8'h00;
    else div_r <= div_r + 8'h01;
  end

  pcl_state_t  state_r;
  logic        sclk_r;
  logic        cs_n_r;
  logic [47:0] sh_r;
  logic [5:0]  cnt_r;
  logic [11:0] gap_r;
  logic        buf_rdy;

  // Flash clock source and stall; a full buffer freezes the clock, not the data
  wire act_st  = (state_r == ST_WAKE) || (state_r == ST_CMD) || (state_r == ST_READ);
  wire tick    = (s_csel == `PCL_SEL_EXT) ? ext_rise : osc_tick;
  wire tick_go = tick && act_st && ((state_r != ST_READ) || buf_rdy);
  wire rise    = tick_go && !sclk_r;
  wire fall    = tick_go && sclk_r;
  // Security mode only narrows further; this build tops out at x8 anyway
  wire werr    = (s_width > `PCL_MAX_WCODE) || (s_sec && s_width > `PCL_MAX_WCODE);

  // Sequencer: wake, gap, fast read from zero, stream
  always_ff @(posedge ref_clk) begin
    if (!reset_n || !s_crst) begin
      state_r <= ST_IDLE;
      cs_n_r  <= 1'b1;
      sclk_r  <= 1'b0;
      sh_r    <= 48'h0;
      cnt_r   <= 6'h00;
      gap_r   <= 12'h000;
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (crst_rise && s_mode == `PCL_MODE_ACTIVE && !werr) begin
            state_r <= ST_WAKE;
            cs_n_r  <= 1'b0;
            sh_r    <= {`PCL_OP_WAKE, 40'h0};
            cnt_r   <= `PCL_CNT_WAKE;
          end else if (crst_rise && s_mode == `PCL_MODE_PASSIVE) begin
            state_r <= ST_PASSIVE;
          end else if (crst_rise && s_mode == `PCL_MODE_JTAG) begin
            state_r <= ST_JTAG;
          end
        end
        ST_WAKE, ST_CMD: begin
          if (rise) begin
            sclk_r <= 1'b1;
          end else if (fall) begin
            sclk_r <= 1'b0;
            sh_r   <= {sh_r[46:0], 1'b0};
            cnt_r  <= cnt_r - 6'h01;
            if (cnt_r == 6'h01 && state_r == ST_WAKE) begin
              state_r <= ST_GAP;
              cs_n_r  <= 1'b1;
              gap_r   <= 12'h000;
            end else if (cnt_r == 6'h01) begin
              state_r <= ST_READ;
            end
          end
        end
        ST_GAP: begin
          gap_r <= gap_r + 12'h001;
          if (gap_r == 12'(WAKE_CYC - 1)) begin
            state_r <= ST_CMD;
            cs_n_r  <= 1'b0;
            sh_r    <= {`PCL_OP_FREAD, 40'h0};
            cnt_r   <= s_addr4 ? `PCL_CNT_RD4 : `PCL_CNT_RD3;
          end
        end
        ST_READ: begin
          if (tick_go) sclk_r <= ~sclk_r;
        end
        ST_PASSIVE, ST_JTAG: begin
          sclk_r <= 1'b0;
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  assign flash_sclk = sclk_r;
  assign flash_cs_n = cs_n_r;
  assign flash_mosi = sh_r[47];
  assign busy       = (state_r != ST_IDLE);

  // Sample selection; x1 flash data returns on dq[1]
  wire       samp_a = rise && (state_r == ST_READ);
  wire       samp_p = (state_r == ST_PASSIVE) && pclk_rise && !s_pcs;
  wire       samp_j = (state_r == ST_JTAG) && jclk_rise && s_jen;
  wire       samp   = ((samp_a || samp_p) && !werr) || samp_j;
  wire [1:0] wcode  = samp_j ? 2'h0 : s_width[1:0];
  wire [7:0] bits_a = (wcode == 2'h0) ? {7'h00, s_dq[1]} : s_dq;
  wire [7:0] bits   = samp_j ? {7'h00, s_jtdi} : (samp_a ? bits_a : s_pdat);

  logic [7:0] acc_r;
  logic [2:0] bc_r;
  logic       done_r;
  logic [7:0] acc_nxt;
  wire  [3:0] bc_nxt = {1'b0, bc_r} + (4'h1 << wcode);
  always_comb begin
    case (wcode)
      2'h0:    acc_nxt = {acc_r[6:0], bits[0]};
      2'h1:    acc_nxt = {acc_r[5:0], bits[1:0]};
      2'h2:    acc_nxt = {acc_r[3:0], bits[3:0]};
      default: acc_nxt = bits;
    endcase
  end

  // Byte assembly, msb first; partial bytes die with config reset
  always_ff @(posedge ref_clk) begin
    if (!reset_n || !s_crst) begin
      acc_r  <= 8'h00;
      bc_r   <= 3'h0;
      done_r <= 1'b0;
    end else begin
      done_r <= samp && bc_nxt[3];
      if (samp) begin
        acc_r <= acc_nxt;
        bc_r  <= bc_nxt[2:0];
      end
    end
  end

  // Status flags; passive and test clocks cannot be stalled, so a lost byte shows
  logic werr_r;
  logic ovr_r;
  always_ff @(posedge ref_clk) begin
    if (!reset_n || !s_crst) begin
      werr_r <= 1'b0;
      ovr_r  <= 1'b0;
    end else begin
      werr_r <= werr && (state_r != ST_JTAG);
      if (done_r && !buf_rdy) ovr_r <= 1'b1;
    end
  end
  assign width_error = werr_r;
  assign overrun     = ovr_r;

  pcl_buf #(.W(8)) u_buf (
    .clk       (ref_clk),
    .reset_n   (reset_n),
    .in_data   (acc_r),
    .in_valid  (done_r),
    .in_ready  (buf_rdy),
    .out_data  (cm_data),
    .out_valid (cm_valid),
    .out_ready (cm_ready)
  );

  // Checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  logic [11:0] hold_r;
  always_ff @(posedge ref_clk) begin
    if (!reset_n || !cs_n_r) hold_r <= 12'h000;
    else if (hold_r != 12'hfff) hold_r <= hold_r + 12'h001;
  end

  sequence s_start;
    state_r == ST_IDLE && crst_rise && s_mode == `PCL_MODE_ACTIVE && !werr && s_crst;
  endsequence
  sequence s_wake_end;
    state_r == ST_WAKE && fall && cnt_r == 6'h01 && s_crst;
  endsequence
  sequence s_cmd_entry;
    state_r == ST_CMD && $past(state_r) == ST_GAP;
  endsequence

  AST_START: assert property (s_start |=> state_r == ST_WAKE && !flash_cs_n
    && sh_r[47:40] == `PCL_OP_WAKE) else $error("active load did not start");
  AST_WAKE_END: assert property (s_wake_end |=> state_r == ST_GAP && flash_cs_n)
    else $error("wake-up not followed by gap");
  AST_GAP_WAIT: assert property (s_cmd_entry |-> $past(hold_r) >= 12'(WAKE_CYC - 1))
    else $error("fast read issued too early");
  AST_CMD_LOAD: assert property (s_cmd_entry |-> sh_r == {`PCL_OP_FREAD, 40'h0}
    && cnt_r == (s_addr4 ? `PCL_CNT_RD4 : `PCL_CNT_RD3)) else $error("bad read header");
  AST_RESET_IDLE: assert property (!s_crst |=> state_r == ST_IDLE && flash_cs_n
    && !flash_sclk && !done_r) else $error("loader active in config reset");
  AST_STALL: assert property (state_r == ST_READ && !buf_rdy && s_crst
    |=> $stable(flash_sclk)) else $error("flash clock ran while stalled");
  AST_EXT_SRC: assert property (s_csel == `PCL_SEL_EXT && !ext_rise && act_st && s_crst
    |=> $stable(flash_sclk)) else $error("flash clock moved without external edge");
  AST_PASSIVE: assert property (samp_p && !werr && wcode == 2'h3 && s_crst |=> done_r)
    else $error("passive x8 sample not accepted");
  AST_WIDTH: assert property (werr && state_r != ST_JTAG |=> !done_r)
    else $error("refused width produced a byte");
  AST_JTAG_BYTE: assert property (samp_j && bc_r == 3'h7 && s_crst |=> done_r
    && bc_r == 3'h0) else $error("test-port byte not completed");
endmodule : pcl_loader

/* sim/pcl_flash_model.sv */
// Serial flash stand-in: records command bits, returns a byte pattern on dq.
// Assumes x8 reads, data sampled by the loader on the rising flash clock.
`timescale 1ns/10ps
module pcl_flash_model (
  input  wire logic        sclk,
  input  wire logic        cs_n,
  input  wire logic        mosi,
  input  wire logic        addr4,
  output logic [7:0]       dq,
  output logic [63:0]      cmd
);
  int bits = 0;

  initial begin
    dq  = 8'h00;
    cmd = 64'h0;
  end

  // Shift in command bits while selected; the count runs on into the data phase
  always @(posedge sclk) begin
    if (!cs_n) begin
      if (bits < (addr4 ? 48 : 40)) cmd = {cmd[62:0], mosi};
      bits = bits + 1;
    end
  end

  // Each frame counts afresh
  always @(posedge cs_n) bits = 0;

  // Data moves on the falling clock; a released bus shows the last byte inverted
  always @(negedge sclk or posedge cs_n) begin
    if (cs_n) dq = ~dq;
    else if (bits >= (addr4 ? 48 : 40)) dq = 8'(bits - (addr4 ? 48 : 40)) * 8'h1d + 8'h5a;
  end
endmodule : pcl_flash_model

/* sim/tb.sv */
// Bench for the configuration loader: active, passive and test-port loads.
// Assumes the flash stand-in on the flash pins and a 100 MHz ref_clk.
`timescale 1ns/10ps
module tb;
  import pcl_pkg::*;
  logic        ref_clk = 0, reset_n = 0, config_reset_n = 0, addr4_sel = 0, clk_sel = 0;
  logic        security_en = 0, external_config_clock = 0, pas_clk = 0, pas_cs_n = 1;
  logic        jtag_clk = 0, jtag_en = 0, jtag_tdi = 0, cm_ready = 0;
  logic [1:0]  mode_sel = 2'h3;
  logic [2:0]  width_sel = 3'h3;
  logic [7:0]  pas_data = 8'h00, flash_dq_i, v;
  logic [7:0]  ov [3];
  logic [63:0] cmd;
  logic        flash_sclk, flash_cs_n, flash_mosi, cm_valid, busy, width_error, overrun;
  pcl_byte_t   cm_data;
  int          fails = 0, n_checks = 0, gap;

  // Loader clock and a free-running external configuration clock
  always #5 ref_clk = ~ref_clk;
  always #40 external_config_clock = ~external_config_clock;

  pcl_loader pcl_loader_inst (.ref_clk, .reset_n, .config_reset_n, .mode_sel, .width_sel,
    .addr4_sel, .clk_sel, .security_en, .external_config_clock, .flash_sclk, .flash_cs_n,
    .flash_mosi, .flash_dq_i, .pas_clk, .pas_cs_n, .pas_data, .jtag_clk, .jtag_en,
    .jtag_tdi, .cm_data, .cm_valid, .cm_ready, .busy, .width_error, .overrun);
  pcl_flash_model pcl_flash_model_inst (.sclk(flash_sclk), .cs_n(flash_cs_n),
    .mosi(flash_mosi), .addr4(addr4_sel), .dq(flash_dq_i), .cmd(cmd));

  task automatic check(string what, logic [63:0] seen, logic [63:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : close_out

  // Byte pattern the flash stand-in returns at read index i
  function automatic logic [7:0] exp_byte(int i);
    return 8'(i) * 8'h1d + 8'h5a;
  endfunction : exp_byte

  // Bounded wait for a flash select level; n is the cycles spent
  task automatic wait_cs(logic lvl, int lim, output int n);
    for (n = 0; n < lim && flash_cs_n !== lvl; n++) @(negedge ref_clk);
    if (n == lim) begin
      fails++;
      close_out();
    end
  endtask : wait_cs

  // Mode is set while the config reset is low, the rising edge starts the load
  task automatic start(logic [1:0] m);
    config_reset_n = 0;
    mode_sel = m;
    repeat (5) @(negedge ref_clk);
    config_reset_n = 1;
  endtask : start

  // Take one output byte; ready stalls at random, drops once the pop edge has passed
  task automatic take(logic [7:0] exp);
    for (int i = 0; i < 3000; i++) begin
      @(negedge ref_clk);
      cm_ready = 1'($urandom_range(1, 0));
      if (cm_valid === 1'b1 && cm_ready === 1'b1) begin
        check("cm_data", cm_data, exp);
        @(negedge ref_clk);
        cm_ready = 1'b0;
        return;
      end
    end
    fails++;
    close_out();
  endtask : take

  // One sample: data settles 2 clk before the rise, rises 6 clk apart
  task automatic samp(logic [7:0] d);
    pas_data = d;
    jtag_tdi = d[0];
    repeat (2) @(negedge ref_clk);
    pas_clk  = 1;
    jtag_clk = 1;
    repeat (3) @(negedge ref_clk);
    pas_clk  = 0;
    jtag_clk = 0;
    @(negedge ref_clk);
  endtask : samp

  // A byte msb first in samples of 2**w bits
  task automatic send(int w, logic [7:0] b);
    int n;
    n = 1 << w;
    for (int k = 0; k < 8 / n; k++) samp(8'((b >> (8 - n * (k + 1))) & ((1 << n) - 1)));
  endtask : send

  // Active load: wake, gap, read command, data, then abort by config reset
  task automatic active(logic a4, logic cs);
    addr4_sel = a4;
    clk_sel   = cs;
    start(2'h0);
    wait_cs(0, 100, gap);
    wait_cs(1, 1000, gap);
    check("wake_op", cmd[7:0], 8'hab);
    wait_cs(0, 5000, gap);
    check("wake_gap", gap >= 3000, 1);
    for (int i = 0; i < 6; i++) take(exp_byte(i));
    check("read_op", a4 ? cmd[47:40] : cmd[39:32], 8'h0b);
    check("read_addr", a4 ? cmd[39:8] : {8'h00, cmd[31:8]}, 0);
    // Buffer survives config reset; drain what the aborted read left behind
    config_reset_n = 0;
    cm_ready = 1;
    repeat (5) @(negedge ref_clk);
    check("abort_cs", flash_cs_n, 1);
    check("abort_busy", busy, 0);
    check("abort_drain", cm_valid, 0);
    cm_ready = 0;
  endtask : active

  initial begin
    void'($urandom(26356));
    repeat (10) @(negedge ref_clk);
    reset_n = 1;
    repeat (5) @(negedge ref_clk);
    check("idle_cs", flash_cs_n, 1);
    check("idle_busy", busy, 0);
    active(0, 0);
    active(1, 1);
    start(2'h3);
    repeat (20) @(negedge ref_clk);
    check("mode3_busy", busy, 0);
    // Passive load keeps the guard time after release, every served width
    pas_cs_n = 0;
    start(2'h1);
    repeat (3200) @(negedge ref_clk);
    for (int w = 0; w < 4; w++) begin
      width_sel = 3'(w);
      v = 8'($urandom);
      send(w, v);
      take(v);
    end
    // Wide widths are refused and produce nothing
    security_en = 1;
    for (int w = 4; w < 6; w++) begin
      width_sel = 3'(w);
      send(3, 8'h5a);
      check("width_error", width_error, 1);
      check("no_byte", cm_valid, 0);
    end
    // Fill the buffer past its two entries with the sink stalled
    width_sel = 3'h3;
    cm_ready  = 0;
    for (int i = 0; i < 3; i++) begin
      ov[i] = 8'($urandom);
      send(3, ov[i]);
    end
    repeat (4) @(negedge ref_clk);
    check("overrun", overrun, 1);
    check("full_valid", cm_valid, 1);
    // Config reset drops the flags; the stored bytes drain, then a test-port byte
    start(2'h2);
    check("overrun_clr", overrun, 0);
    take(ov[0]);
    take(ov[1]);
    jtag_en = 1;
    v = 8'($urandom);
    send(0, v);
    take(v);
    close_out();
  end
endmodule : tb
